// ---- shared/alc_defs.vh ----
`ifndef ALC_DEFS_VH
`define ALC_DEFS_VH

// Register indices; the byte address on the bus is four times the index
`define ALC_IDX_CHAN_MODE  8'h10
`define ALC_IDX_LVDS_CFG   8'h18
`define ALC_IDX_LEN_LO     8'h20
`define ALC_IDX_LEN_HI     8'h21
`define ALC_IDX_TRIM       8'h30
`define ALC_IDX_TP_CTL     8'h31
`define ALC_IDX_STATUS     8'h32

// Field positions
`define ALC_MODE_LSB       5
`define ALC_MODE_MSB       6
`define ALC_LR_BIT         7
`define ALC_SINGLE_BIT     4
`define ALC_TP_EN_BIT      0
`define ALC_HI_MSB         3

// DSI channel mode encodings
`define ALC_MODE_DUAL      2'h0
`define ALC_MODE_SINGLE    2'h1
`define ALC_MODE_STREAM    2'h2

// Line length meaning, one-hot
`define ALC_MEAN_SINGLE    4'h1
`define ALC_MEAN_ODD       4'h2
`define ALC_MEAN_LEFT      4'h4
`define ALC_MEAN_STREAM    4'h8

// Reset values
`define ALC_RST_LEN_LO     8'h00
`define ALC_RST_LEN_HI     4'h0
`define ALC_RST_MODE       2'h1
`define ALC_RST_LR         1'b0
`define ALC_RST_SINGLE     1'b1
`define ALC_RST_TRIM       8'h00
`define ALC_RST_TP_EN      1'b0

// AHB encodings
`define ALC_HTRANS_NONSEQ  2'h2
`define ALC_HRESP_OKAY     1'b0

`endif

// ---- rtl/alc_route.v ----
`include "alc_defs.vh"

// Decode of channel mode and LVDS select into routing and meaning flags
module alc_route (
  input  wire [1:0] mode,
  input  wire       left_right,
  input  wire       single_lvds,
  input  wire       tp_en,
  output reg  [3:0] meaning,
  output reg        use_second_set,
  output reg        tp_from_second,
  output reg        sync_offset_en,
  output reg        odd_to_both
);

  // Pure decode; the caller registers the results
  always @* begin
    meaning        = `ALC_MEAN_SINGLE;
    use_second_set = 1'b0;
    odd_to_both    = 1'b0;
    case (mode)
      `ALC_MODE_SINGLE: begin
        meaning = `ALC_MEAN_SINGLE;                 // [RULE7]
      end
      `ALC_MODE_STREAM: begin
        meaning = `ALC_MEAN_STREAM;                 // [RULE10]
        use_second_set = ~single_lvds;              // [RULE3] [RULE6]
      end
      `ALC_MODE_DUAL: begin
        if (left_right) begin
          meaning = `ALC_MEAN_LEFT;                 // [RULE9]
        end else begin
          meaning = `ALC_MEAN_ODD;                  // [RULE8]
          odd_to_both = ~single_lvds;               // [RULE8]
        end
      end
      default: begin
        // Reserved code behaves as a single input
        meaning = `ALC_MEAN_SINGLE;
      end
    endcase
    // Test pattern takes set A except in two-stream dual LVDS
    tp_from_second = tp_en & use_second_set;        // [RULE5]
    // Sync offsets never apply while the pattern runs
    sync_offset_en = ~tp_en;                        // [RULE4]
  end

endmodule // alc_route

// ---- rtl/alc_regs.v ----
// Summary of operation
// [RULE1]: Test-pattern-only values act only while the test pattern runs.
// [RULE2]: Other timing values drive normal video and also the test pattern.
// [RULE3]: Second register set used only with dual LVDS and mode 10.
// [RULE4]: Sync offsets are ignored while generating the test pattern.
// [RULE5]: Otherwise the test pattern takes timing from the first set.
// [RULE6]: Mode-10-only second-set fields act only in mode 10, dual LVDS.
// [RULE7]: Single input: value is pixels per active line.
// [RULE8]: Odd/even: value counts odd pixels from input A, to A or both.
// [RULE9]: Left/right: value counts left pixels from input A to output A.
// [RULE10]: Two stream: value counts pixels of stream A per line.
// [RULE11]: Low register holds the low eight bits of twelve.
// [RULE12]: High register bits 3:0 hold the top four bits.
// [RULE13]: Software programs the length after left trim in left/right mode.
// [RULE14]: Both parts form one count; reads return last written value.
//
// Chosen here: register access over AHB-Lite.
`include "alc_defs.vh"

module alc_regs (
  input  wire        CORE_CLK,
  input  wire        RESETN,
  // AHB-Lite slave
  input  wire        HSEL,
  input  wire [31:0] HADDR,
  input  wire [1:0]  HTRANS,
  input  wire        HWRITE,
  input  wire [2:0]  HSIZE,
  input  wire [31:0] HWDATA,
  input  wire        HREADY,
  output wire        HREADYOUT,
  output wire        HRESP,
  output wire [31:0] HRDATA,
  // Configuration seen by the video path
  output wire [11:0] VIDEO_LINE_LENGTH,
  output wire [11:0] TP_LINE_LENGTH,
  output wire [3:0]  LINE_MEANING,
  output wire        USE_SECOND_SET,
  output wire        TP_FROM_SECOND_SET,
  output wire        SYNC_OFFSET_EN,
  output wire        ODD_TO_BOTH_LVDS,
  output wire        TRIM_ACTIVE,
  output wire [7:0]  LEFT_TRIM
);

  // Register map by word index; the byte address is four times the index
  //   0x10  channel mode: [6:5] mode code, [7] left/right in mode 00
  //   0x18  output config: [4] single output channel, set after reset
  //   0x20  line length, low byte
  //   0x21  line length, high nibble in [3:0]
  //   0x30  left portion trim, passed on to the video path
  //   0x31  test pattern enable in [0]
  //   0x32  status, read only: what the video path uses right now
  // Reserved bits read zero and drop writes; unmapped words read zero

  // Bus data-phase tracker, one-hot
  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_WRITE = 3'h2;
  localparam [2:0] ST_RWAIT = 3'h4;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  wire        wr_pend;
  wire        rd_wait;
  reg  [7:0]  idx_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  wire        take;
  wire [7:0]  haddr_idx;

  // Write strobes, one per register, valid in the write data phase
  wire        wr_len_lo;
  wire        wr_len_hi;
  wire        wr_mode;
  wire        wr_lvds;
  wire        wr_trim;
  wire        wr_tp;

  // Limitations:
  //   - whole-word single transfers only; HSIZE is not decoded
  //   - the trim value is passed on; the length is not reduced here, so
  //     software programs the portion that is left after trimming
  //   - mode code 11 is reserved and behaves as a single input
  //   - the second channel's own registers live outside this block; only
  //     the flags that say when they apply are produced here

  // Software visible storage
  reg  [7:0]  len_lo_q;
  reg  [3:0]  len_hi_q;
  reg  [1:0]  mode_q;
  reg         lr_q;
  reg         single_q;
  reg  [7:0]  trim_q;
  reg         tp_en_q;

  // Registered outputs to the video path
  reg  [11:0] video_len_q;
  reg  [11:0] tp_len_q;
  reg  [3:0]  meaning_q;
  reg         use_b_q;
  reg         tp_b_q;
  reg         sync_en_q;
  reg         odd_both_q;
  reg         trim_act_q;
  reg  [7:0]  left_trim_q;

  // Decoder results
  wire [3:0]  meaning_w;
  wire        use_b_w;
  wire        tp_b_w;
  wire        sync_en_w;
  wire        odd_both_w;
  wire [11:0] len_w;

  // Word index sits above the two byte bits
  assign haddr_idx = HADDR[9:2];
  assign take = HSEL & HREADY & (HTRANS == `ALC_HTRANS_NONSEQ);

  // Both halves read as one twelve-bit count
  assign len_w = {len_hi_q, len_lo_q};              // [RULE14]

  alc_route u_route (
    .mode           (mode_q),
    .left_right     (lr_q),
    .single_lvds    (single_q),
    .tp_en          (tp_en_q),
    .meaning        (meaning_w),
    .use_second_set (use_b_w),
    .tp_from_second (tp_b_w),
    .sync_offset_en (sync_en_w),
    .odd_to_both    (odd_both_w)
  );

  // Next data phase; a transfer is taken only while the bus is ready
  always @* begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE, ST_WRITE: begin
        if (take) begin
          state_d = HWRITE ? ST_WRITE : ST_RWAIT;
        end
      end
      ST_RWAIT: begin
        // Reads get one wait state so their data come from a flop
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Data-phase state and the index of the word being served
  // Index is held through the data phase, so HADDR may move on
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_IDLE;
      idx_q   <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        idx_q <= haddr_idx;
      end
    end
  end

  // Decoded phase flags
  assign wr_pend = (state_q == ST_WRITE);
  assign rd_wait = (state_q == ST_RWAIT);

  // A pipelined address phase may overlap a write data phase; the write
  // still uses the index captured one edge earlier
  assign wr_len_lo = wr_pend & (idx_q == `ALC_IDX_LEN_LO);
  assign wr_len_hi = wr_pend & (idx_q == `ALC_IDX_LEN_HI);
  assign wr_mode   = wr_pend & (idx_q == `ALC_IDX_CHAN_MODE);
  assign wr_lvds   = wr_pend & (idx_q == `ALC_IDX_LVDS_CFG);
  assign wr_trim   = wr_pend & (idx_q == `ALC_IDX_TRIM);
  assign wr_tp     = wr_pend & (idx_q == `ALC_IDX_TP_CTL);

  // Stall only the first data-phase cycle of a read
  assign HREADYOUT = ~rd_wait;
  assign HRESP     = `ALC_HRESP_OKAY;
  assign HRDATA    = rdata_q;

  // Write data phase; unmapped indices are ignored
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      len_lo_q <= `ALC_RST_LEN_LO;
      len_hi_q <= `ALC_RST_LEN_HI;
      mode_q   <= `ALC_RST_MODE;
      lr_q     <= `ALC_RST_LR;
      single_q <= `ALC_RST_SINGLE;
      trim_q   <= `ALC_RST_TRIM;
      tp_en_q  <= `ALC_RST_TP_EN;
    end else begin
      // Each strobe writes one register; other bits are reserved
      if (wr_len_lo) begin
        len_lo_q <= HWDATA[7:0];                    // [RULE11]
      end
      if (wr_len_hi) begin
        len_hi_q <= HWDATA[`ALC_HI_MSB:0];          // [RULE12]
      end
      if (wr_mode) begin
        mode_q <= HWDATA[`ALC_MODE_MSB:`ALC_MODE_LSB];
        lr_q   <= HWDATA[`ALC_LR_BIT];
      end
      if (wr_lvds) begin
        single_q <= HWDATA[`ALC_SINGLE_BIT];
      end
      if (wr_trim) begin
        trim_q <= HWDATA[7:0];
      end
      if (wr_tp) begin
        tp_en_q <= HWDATA[`ALC_TP_EN_BIT];
      end
    end
  end

  // Read mux; reserved bits and unmapped indices read zero
  // Decoded from the captured index, so the address may already move on
  always @* begin
    rdata_d = 32'h0000_0000;
    case (idx_q)
      `ALC_IDX_LEN_LO: begin
        rdata_d[7:0] = len_lo_q;                    // [RULE14]
      end
      `ALC_IDX_LEN_HI: begin
        rdata_d[`ALC_HI_MSB:0] = len_hi_q;          // [RULE14]
      end
      `ALC_IDX_CHAN_MODE: begin
        rdata_d[`ALC_MODE_MSB:`ALC_MODE_LSB] = mode_q;
        rdata_d[`ALC_LR_BIT] = lr_q;
      end
      `ALC_IDX_LVDS_CFG: begin
        rdata_d[`ALC_SINGLE_BIT] = single_q;
      end
      `ALC_IDX_TRIM: begin
        rdata_d[7:0] = trim_q;
      end
      `ALC_IDX_TP_CTL: begin
        rdata_d[`ALC_TP_EN_BIT] = tp_en_q;
      end
      `ALC_IDX_STATUS: begin
        // Live view of what the video path is using
        rdata_d[11:0]  = video_len_q;
        rdata_d[15:12] = meaning_q;
        rdata_d[16]    = use_b_q;
        rdata_d[17]    = tp_b_q;
        rdata_d[18]    = sync_en_q;
        rdata_d[19]    = odd_both_q;
        rdata_d[20]    = trim_act_q;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Read data loaded in the wait cycle, after any prior write landed
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_wait) begin
      rdata_q <= rdata_d;
    end
  end

  // Video path configuration, one cycle after the register changes
  // Costs a cycle but keeps the video path off the bus decode timing
  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      video_len_q <= 12'h000;
      tp_len_q    <= 12'h000;
      meaning_q   <= `ALC_MEAN_SINGLE;
      use_b_q     <= 1'b0;
      tp_b_q      <= 1'b0;
      sync_en_q   <= 1'b1;
      odd_both_q  <= 1'b0;
      trim_act_q  <= 1'b0;
      left_trim_q <= `ALC_RST_TRIM;
    end else begin
      // Normal video always follows the set A length
      video_len_q <= len_w;                          // [RULE2]
      // Pattern copy held at zero unless the pattern runs
      tp_len_q    <= tp_en_q ? len_w : 12'h000;      // [RULE1] [RULE2]
      meaning_q   <= meaning_w;
      use_b_q     <= use_b_w;                        // [RULE3] [RULE6]
      tp_b_q      <= tp_b_w;                         // [RULE5]
      sync_en_q   <= sync_en_w;                      // [RULE4]
      odd_both_q  <= odd_both_w;                     // [RULE8]
      // Length is taken as already trimmed by software
      trim_act_q  <= (meaning_w == `ALC_MEAN_LEFT) &&
                     (trim_q != 8'h00);              // [RULE13]
      // Trim copy moves with the flag so the two never disagree
      left_trim_q <= trim_q;
    end
  end

  assign VIDEO_LINE_LENGTH  = video_len_q;
  assign TP_LINE_LENGTH     = tp_len_q;
  assign LINE_MEANING       = meaning_q;
  assign USE_SECOND_SET     = use_b_q;
  assign TP_FROM_SECOND_SET = tp_b_q;
  assign SYNC_OFFSET_EN     = sync_en_q;
  assign ODD_TO_BOTH_LVDS   = odd_both_q;
  assign TRIM_ACTIVE        = trim_act_q;
  assign LEFT_TRIM          = left_trim_q;

endmodule // alc_regs

// ---- sim/alc_regs_sva.sv ----
`include "alc_defs.vh"

module alc_regs_sva (
  input wire        CORE_CLK,
  input wire        RESETN,
  input wire        HSEL,
  input wire [31:0] HADDR,
  input wire [1:0]  HTRANS,
  input wire        HWRITE,
  input wire [31:0] HWDATA,
  input wire        HREADY,
  input wire        HREADYOUT,
  input wire        HRESP,
  input wire [11:0] VIDEO_LINE_LENGTH,
  input wire [11:0] TP_LINE_LENGTH,
  input wire [3:0]  LINE_MEANING,
  input wire        USE_SECOND_SET,
  input wire        TP_FROM_SECOND_SET,
  input wire        SYNC_OFFSET_EN,
  input wire        ODD_TO_BOTH_LVDS,
  input wire        TRIM_ACTIVE,
  input wire [7:0]  LEFT_TRIM
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  // Transfer taken at this edge, and its register index
  wire       tk  = HSEL & HREADY & (HTRANS == `ALC_HTRANS_NONSEQ);
  wire [7:0] idx = HADDR[9:2];

  a_resp_okay: assert property (HRESP == `ALC_HRESP_OKAY)
    else $error("bus response not okay");
  a_low_byte: assert property (tk && HWRITE
    && idx == `ALC_IDX_LEN_LO
    |=> ##2 VIDEO_LINE_LENGTH[7:0] == $past(HWDATA[7:0], 2))
    else $error("low byte of line length wrong");
  a_high_nib: assert property (tk && HWRITE
    && idx == `ALC_IDX_LEN_HI
    |=> ##2 VIDEO_LINE_LENGTH[11:8] == $past(HWDATA[3:0], 2))
    else $error("high nibble of line length wrong");
  a_read_wait: assert property (tk && !HWRITE
    |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read data phase not one wait");
  a_tp_length: assert property (TP_LINE_LENGTH ==
    (SYNC_OFFSET_EN ? 12'h000 : VIDEO_LINE_LENGTH))
    else $error("pattern length wrong");
  a_tp_second: assert property (TP_FROM_SECOND_SET ==
    (USE_SECOND_SET && !SYNC_OFFSET_EN))
    else $error("pattern set choice wrong");
  a_odd_both: assert property (ODD_TO_BOTH_LVDS |->
    LINE_MEANING == `ALC_MEAN_ODD && !USE_SECOND_SET)
    else $error("odd split outside odd mode");
  a_second_mode: assert property (USE_SECOND_SET |->
    LINE_MEANING == `ALC_MEAN_STREAM)
    else $error("second set outside stream mode");
  a_trim_left: assert property (TRIM_ACTIVE |->
    LINE_MEANING == `ALC_MEAN_LEFT && LEFT_TRIM != 8'h00)
    else $error("trim outside left mode");
  a_one_meaning: assert property ($onehot(LINE_MEANING))
    else $error("meaning not one-hot");

  c_read: cover property (tk && !HWRITE);
  c_second: cover property (TP_FROM_SECOND_SET);
  c_trim: cover property (TRIM_ACTIVE);
endmodule // alc_regs_sva

bind alc_regs alc_regs_sva u_sva (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .VIDEO_LINE_LENGTH(VIDEO_LINE_LENGTH), .TP_LINE_LENGTH(TP_LINE_LENGTH),
  .LINE_MEANING(LINE_MEANING), .USE_SECOND_SET(USE_SECOND_SET),
  .TP_FROM_SECOND_SET(TP_FROM_SECOND_SET), .SYNC_OFFSET_EN(SYNC_OFFSET_EN),
  .ODD_TO_BOTH_LVDS(ODD_TO_BOTH_LVDS), .TRIM_ACTIVE(TRIM_ACTIVE),
  .LEFT_TRIM(LEFT_TRIM));

// ---- sim/alc_host.sv ----
module alc_host (
  input  wire        clk,
  input  wire        hready,
  input  wire [31:0] hrdata,
  output logic       hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic       hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One word; signals move just after a rising edge, and ready and read
  // data are taken at the rising edge itself
  task automatic xfer(input logic [7:0] idx, input logic wr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
    hwdata <= ~wd; // Released data never shows the old value
  endtask
endmodule // alc_host

// ---- sim/tb_top.sv ----
`include "alc_defs.vh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  wire         hsel, hwrite, hrdy, hresp, use2, tp2, syn, odd2, trim;
  wire  [31:0] haddr, hwdata, hrdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  wire  [11:0] vlen, tlen;
  wire  [3:0]  mean;
  wire  [7:0]  ltrim;
  logic [31:0] v;
  int          mismatches = 0;
  int          total_checks = 0;
  // Mode, LVDS config, expected {meaning, second set, odd to both}
  logic [23:0] cfg [6] = '{24'h201004, 24'h000009, 24'h001008,
                           24'h800010, 24'h600004, 24'h400022};

  always #20 core_clk = ~core_clk;

  alc_regs DUT (.CORE_CLK(core_clk), .RESETN(resetn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy), .HRESP(hresp),
    .HRDATA(hrdata), .VIDEO_LINE_LENGTH(vlen), .TP_LINE_LENGTH(tlen),
    .LINE_MEANING(mean), .USE_SECOND_SET(use2), .TP_FROM_SECOND_SET(tp2),
    .SYNC_OFFSET_EN(syn), .ODD_TO_BOTH_LVDS(odd2), .TRIM_ACTIVE(trim),
    .LEFT_TRIM(ltrim));

  alc_host u_host (.clk(core_clk), .hready(hrdy), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write, then let the registered outputs follow
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    u_host.xfer(idx, 1'b1, d, v);
    repeat (2) @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    u_host.xfer(idx, 1'b0, 32'h0, v);
    chk(v, exp);
    chk(hresp, 1'b0);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog well beyond the roughly 160 cycles of the tests
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk({mean, use2, syn, vlen}, {4'h1, 2'b01, 12'h000});
    rchk(`ALC_IDX_LEN_LO, 32'h0);
    rchk(`ALC_IDX_LEN_HI, 32'h0);
    $display("reset test done");
    wr(`ALC_IDX_LEN_LO, 32'hFFFF_FFA5);
    wr(`ALC_IDX_LEN_HI, 32'hFFFF_FFF7);
    rchk(`ALC_IDX_LEN_LO, 32'hA5);
    rchk(`ALC_IDX_LEN_HI, 32'h7);
    chk(vlen, 12'h7A5);
    rchk(8'h3F, 32'h0);
    $display("length test done");
    for (int i = 0; i < 6; i++) begin
      wr(`ALC_IDX_CHAN_MODE, {24'h0, cfg[i][23:16]});
      wr(`ALC_IDX_LVDS_CFG, {24'h0, cfg[i][15:8]});
      chk(mean, cfg[i][5:2]);
      chk({use2, odd2}, cfg[i][1:0]);
    end
    $display("mode test done");
    wr(`ALC_IDX_TP_CTL, 32'h1);
    chk({tp2, syn, tlen}, {2'b10, 12'h7A5});
    chk(vlen, 12'h7A5);
    wr(`ALC_IDX_LVDS_CFG, 32'h10);
    chk({use2, tp2, tlen}, {2'b00, 12'h7A5});
    wr(`ALC_IDX_TP_CTL, 32'h0);
    chk({syn, tlen}, {1'b1, 12'h000});
    rchk(`ALC_IDX_LVDS_CFG, 32'h10);
    rchk(`ALC_IDX_TP_CTL, 32'h0);
    $display("pattern test done");
    wr(`ALC_IDX_CHAN_MODE, 32'h80);
    wr(`ALC_IDX_TRIM, 32'h10);
    wr(`ALC_IDX_LEN_LO, 32'h95);
    chk({trim, ltrim, vlen}, {1'b1, 8'h10, 12'h795});
    rchk(`ALC_IDX_CHAN_MODE, 32'h80);
    rchk(`ALC_IDX_TRIM, 32'h10);
    rchk(`ALC_IDX_STATUS, 32'h0014_4795);
    wr(`ALC_IDX_TRIM, 32'h0);
    chk({trim, ltrim}, 9'h000);
    $display("trim test done");
    finish_test();
  end
endmodule // tb_top
